// file: cnc_pkg.sv
package cnc_pkg;
   localparam int CNC_ADDR_W = 16;
   localparam int CNC_DATA_W = 16;

   localparam logic [15:0] CNC_OFF_ADV_CTRL = 16'h01F0;
   localparam logic [15:0] CNC_OFF_TCP_PORT = 16'h024B;
   localparam logic [15:0] CNC_OFF_STREAM_LOW = 16'h024C;
   localparam logic [15:0] CNC_OFF_STREAM_HIGH = 16'h024D;
   localparam logic [15:0] CNC_OFF_STREAM_PORT = 16'h024E;
   localparam logic [15:0] CNC_OFF_COLOUR_LOW = 16'h0256;
   localparam logic [15:0] CNC_OFF_COLOUR_HIGH = 16'h0257;
   localparam logic [15:0] CNC_OFF_COLOUR_PORT = 16'h0258;
   localparam logic [15:0] CNC_OFF_PKT_LEN = 16'h0259;
   localparam logic [15:0] CNC_OFF_LINK_RATE = 16'h025A;

   localparam logic [15:0] CNC_RST_ADV_CTRL = 16'h0000;
   localparam logic [15:0] CNC_RST_TCP_PORT = 16'h2711;
   localparam logic [15:0] CNC_RST_ADDR_LOW = 16'h0001;
   localparam logic [15:0] CNC_RST_ADDR_HIGH = 16'hE000;
   localparam logic [15:0] CNC_RST_STREAM_PORT = 16'h2712;
   localparam logic [15:0] CNC_RST_COLOUR_PORT = 16'h2716;
   localparam logic [15:0] CNC_RST_PKT_LEN = 16'h0578;
   localparam logic [15:0] CNC_RST_LINK_RATE = 16'h03E8;
   localparam logic [15:0] CNC_RDATA_ZERO = 16'h0000;

   localparam int CNC_BIT_HDR = 0;
   localparam int CNC_BIT_PATH_CORR = 3;
   localparam int CNC_BIT_VERNIER = 7;
endpackage : cnc_pkg

// file: cnc_commit_if.sv
`timescale 1ns/100ps
interface cnc_commit_if;
   logic wr_low;
   logic wr_high;
   logic [15:0] wdata;
   logic [15:0] low_q;
   logic [15:0] high_q;
   logic [31:0] active_q;

   modport ctrl (output wr_low, output wr_high, output wdata, input low_q, input high_q, input active_q);
   modport keeper (input wr_low, input wr_high, input wdata, output low_q, output high_q, output active_q);
endinterface : cnc_commit_if

// file: cnc_addr_commit.sv
`timescale 1ns/100ps
module cnc_addr_commit
(
   input wire logic clk,
   input wire logic nrst,
   cnc_commit_if.keeper port_if
);
   import cnc_pkg::*;

   logic [15:0] low_reg;
   logic [15:0] high_reg;
   logic [31:0] active_reg;

   // Low half only parks the value; only low_q readback sees it, active_q does not yet
   always_ff @(posedge clk) begin
      if (!nrst) begin
         low_reg <= CNC_RST_ADDR_LOW;
      end else if (port_if.wr_low) begin
         low_reg <= port_if.wdata; // R4 R11
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         high_reg <= CNC_RST_ADDR_HIGH;
      end else if (port_if.wr_high) begin
         high_reg <= port_if.wdata;
      end
   end

   // High write commits both halves at once, so the active pair never tears
   always_ff @(posedge clk) begin
      if (!nrst) begin
         active_reg <= {CNC_RST_ADDR_HIGH, CNC_RST_ADDR_LOW};
      end else if (port_if.wr_high) begin
         active_reg <= {port_if.wdata, low_reg}; // R5 R6
      end
   end

   assign port_if.low_q = low_reg;
   assign port_if.high_q = high_reg;
   assign port_if.active_q = active_reg;

   a_low_no_commit: // R4
   assert property (@(posedge clk) disable iff (!nrst)
      (port_if.wr_low && !port_if.wr_high) |=> (active_reg == $past(active_reg)))
      else $error("low half write changed active address");

   a_high_commits: // R5
   assert property (@(posedge clk) disable iff (!nrst)
      port_if.wr_high |=> (active_reg == {$past(port_if.wdata), $past(low_reg)}))
      else $error("high half write did not commit both halves");

   a_pending_then_commit: // R11
   assert property (@(posedge clk) disable iff (!nrst)
      (port_if.wr_low && !port_if.wr_high) ##1 port_if.wr_high
      |=> (active_reg[15:0] == $past(port_if.wdata, 2)))
      else $error("pending low half lost before commit");
endmodule : cnc_addr_commit

// file: cnc_net_adv_config_regs.sv
//Behaviour
//R1: Bit 0 enables combined HDR sequence merge
//R2: Bit 3 enables path length correction
//R3: Bit 7 enables vernier processing
//R4: Depth low address write only held pending
//R5: Depth high address write commits both halves
//R6: Colour high address write updates active destination
//R7: Control TCP port register, reset 2711
//R8: Depth stream UDP port, reset 2712
//R9: Colour stream UDP port, reset 2716
//R10: UDP packet length register, reset 0578
//R11: Colour low address held until high write
//R12: Link rate read-only, shows negotiated rate
`timescale 1ns/100ps
module cnc_net_adv_config_regs
#(
   parameter int ADDR_W = cnc_pkg::CNC_ADDR_W
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [cnc_pkg::CNC_DATA_W-1:0] wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [cnc_pkg::CNC_DATA_W-1:0] rdata,
   input wire logic [15:0] link_rate_mbps,
   output logic hdr_combine_en,
   output logic path_corr_en,
   output logic vernier_en,
   output logic [15:0] ctrl_tcp_port,
   output logic [31:0] stream_dest_addr,
   output logic [15:0] stream_port,
   output logic [31:0] colour_dest_addr,
   output logic [15:0] colour_port,
   output logic [15:0] udp_pkt_len
);
   import cnc_pkg::*;

   if (ADDR_W < 10 || ADDR_W > 16) begin : g_bad_addr_w
      $error("ADDR_W must be 10 to 16 bits");
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
      hit = (CNC_ADDR_W'(a) == off);
   endfunction : hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, CNC_OFF_ADV_CTRL) || hit(a, CNC_OFF_TCP_PORT) || hit(a, CNC_OFF_STREAM_LOW)
               || hit(a, CNC_OFF_STREAM_HIGH) || hit(a, CNC_OFF_STREAM_PORT) || hit(a, CNC_OFF_COLOUR_LOW)
               || hit(a, CNC_OFF_COLOUR_HIGH) || hit(a, CNC_OFF_COLOUR_PORT) || hit(a, CNC_OFF_PKT_LEN)
               || hit(a, CNC_OFF_LINK_RATE);
   endfunction : mapped

   logic [15:0] adv_ctrl_reg;
   logic [15:0] tcp_port_reg;
   logic [15:0] stream_port_reg;
   logic [15:0] colour_port_reg;
   logic [15:0] pkt_len_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic hdr_reg;
   logic path_corr_reg;
   logic vernier_reg;

   cnc_commit_if stream_if ();
   cnc_commit_if colour_if ();

   assign stream_if.wr_low = wr_strobe && hit(addr, CNC_OFF_STREAM_LOW); // R4
   assign stream_if.wr_high = wr_strobe && hit(addr, CNC_OFF_STREAM_HIGH); // R5
   assign stream_if.wdata = wdata;
   assign colour_if.wr_low = wr_strobe && hit(addr, CNC_OFF_COLOUR_LOW); // R11
   assign colour_if.wr_high = wr_strobe && hit(addr, CNC_OFF_COLOUR_HIGH); // R6
   assign colour_if.wdata = wdata;

   cnc_addr_commit u_stream_addr (
      .clk(clk),
      .nrst(nrst),
      .port_if(stream_if.keeper)
   );

   cnc_addr_commit u_colour_addr (
      .clk(clk),
      .nrst(nrst),
      .port_if(colour_if.keeper)
   );

   // Whole word kept so unused bits read back as written
   always_ff @(posedge clk) begin
      if (!nrst) begin
         adv_ctrl_reg <= CNC_RST_ADV_CTRL;
      end else if (wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) begin
         adv_ctrl_reg <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         hdr_reg <= 1'b0;
         path_corr_reg <= 1'b0;
         vernier_reg <= 1'b0;
      end else if (wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) begin
         hdr_reg <= wdata[CNC_BIT_HDR]; // R1
         path_corr_reg <= wdata[CNC_BIT_PATH_CORR]; // R2
         vernier_reg <= wdata[CNC_BIT_VERNIER]; // R3
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tcp_port_reg <= CNC_RST_TCP_PORT;
      end else if (wr_strobe && hit(addr, CNC_OFF_TCP_PORT)) begin
         tcp_port_reg <= wdata; // R7
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stream_port_reg <= CNC_RST_STREAM_PORT;
      end else if (wr_strobe && hit(addr, CNC_OFF_STREAM_PORT)) begin
         stream_port_reg <= wdata; // R8
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         colour_port_reg <= CNC_RST_COLOUR_PORT;
      end else if (wr_strobe && hit(addr, CNC_OFF_COLOUR_PORT)) begin
         colour_port_reg <= wdata; // R9
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pkt_len_reg <= CNC_RST_PKT_LEN;
      end else if (wr_strobe && hit(addr, CNC_OFF_PKT_LEN)) begin
         pkt_len_reg <= wdata; // R10
      end
   end

   always_comb begin
      rdata_next = CNC_RDATA_ZERO;
      if (rd_strobe) begin
         if (hit(addr, CNC_OFF_ADV_CTRL)) begin
            rdata_next = adv_ctrl_reg;
         end else if (hit(addr, CNC_OFF_TCP_PORT)) begin
            rdata_next = tcp_port_reg;
         end else if (hit(addr, CNC_OFF_STREAM_LOW)) begin
            rdata_next = stream_if.low_q;
         end else if (hit(addr, CNC_OFF_STREAM_HIGH)) begin
            rdata_next = stream_if.high_q;
         end else if (hit(addr, CNC_OFF_STREAM_PORT)) begin
            rdata_next = stream_port_reg;
         end else if (hit(addr, CNC_OFF_COLOUR_LOW)) begin
            rdata_next = colour_if.low_q;
         end else if (hit(addr, CNC_OFF_COLOUR_HIGH)) begin
            rdata_next = colour_if.high_q;
         end else if (hit(addr, CNC_OFF_COLOUR_PORT)) begin
            rdata_next = colour_port_reg;
         end else if (hit(addr, CNC_OFF_PKT_LEN)) begin
            rdata_next = pkt_len_reg;
         end else if (hit(addr, CNC_OFF_LINK_RATE)) begin
            rdata_next = link_rate_mbps; // R12
         end
      end
   end

   // Data stands for one cycle only, zero otherwise
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_reg <= CNC_RDATA_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign hdr_combine_en = hdr_reg;
   assign path_corr_en = path_corr_reg;
   assign vernier_en = vernier_reg;
   assign ctrl_tcp_port = tcp_port_reg;
   assign stream_dest_addr = stream_if.active_q;
   assign stream_port = stream_port_reg;
   assign colour_dest_addr = colour_if.active_q;
   assign colour_port = colour_port_reg;
   assign udp_pkt_len = pkt_len_reg;

   a_hdr_follows_write: // R1
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> (hdr_combine_en == $past(wdata[CNC_BIT_HDR])))
      else $error("combine enable does not follow bit 0");

   a_path_corr_write: // R2
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> (path_corr_en == $past(wdata[CNC_BIT_PATH_CORR])))
      else $error("path correction enable does not follow bit 3");

   a_vernier_stable: // R3
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> $stable(vernier_en))
      else $error("vernier enable changed without a write");

   a_vernier_write: // R3
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> (vernier_en == $past(wdata[CNC_BIT_VERNIER])))
      else $error("vernier enable does not follow bit 7");

   a_port_reset_vals: // R7
   assert property (@(posedge clk)
      !nrst |=> (ctrl_tcp_port == CNC_RST_TCP_PORT && stream_port == CNC_RST_STREAM_PORT
                        && colour_port == CNC_RST_COLOUR_PORT && udp_pkt_len == CNC_RST_PKT_LEN))
      else $error("port or length reset value wrong");

   a_stream_port_write: // R8
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_STREAM_PORT)) |=> (stream_port == $past(wdata)))
      else $error("stream port write not taken");

   a_colour_port_write: // R9
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_COLOUR_PORT)) |=> (colour_port == $past(wdata)))
      else $error("colour port write not taken");

   a_pkt_len_readback: // R10
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_strobe && hit(addr, CNC_OFF_PKT_LEN)) |=> (rdata == udp_pkt_len))
      else $error("packet length readback mismatch");

   a_colour_commit: // R6
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_COLOUR_HIGH)) |=> (colour_dest_addr[31:16] == $past(wdata)))
      else $error("colour high write did not update destination");

   a_link_rate_read: // R12
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_strobe && hit(addr, CNC_OFF_LINK_RATE)) |=> (rdata == $past(link_rate_mbps)))
      else $error("link rate read does not show input rate");

   a_rdata_one_cycle:
   assert property (@(posedge clk) disable iff (!nrst)
      !rd_strobe |=> (rdata == CNC_RDATA_ZERO))
      else $error("read data present without a read");

   a_enable_reset: // R1
   assert property (@(posedge clk)
      !nrst |=> (!hdr_combine_en && !path_corr_en && !vernier_en))
      else $error("processing enables not cleared by reset");

   a_dest_reset: // R5
   assert property (@(posedge clk)
      !nrst |=> (stream_dest_addr == {CNC_RST_ADDR_HIGH, CNC_RST_ADDR_LOW}
                 && colour_dest_addr == {CNC_RST_ADDR_HIGH, CNC_RST_ADDR_LOW}))
      else $error("destination address reset value wrong");

   a_rdata_reset:
   assert property (@(posedge clk)
      !nrst |=> (rdata == CNC_RDATA_ZERO))
      else $error("read data not cleared by reset");

   a_hdr_stable: // R1
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> $stable(hdr_combine_en))
      else $error("combine enable changed without a write");

   a_path_corr_stable: // R2
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> $stable(path_corr_en))
      else $error("path correction enable changed without a write");

   a_tcp_port_write: // R7
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_TCP_PORT)) |=> (ctrl_tcp_port == $past(wdata)))
      else $error("control port write not taken");

   a_tcp_port_stable: // R7
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_TCP_PORT)) |=> $stable(ctrl_tcp_port))
      else $error("control port changed without a write");

   a_stream_port_stable: // R8
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_STREAM_PORT)) |=> $stable(stream_port))
      else $error("stream port changed without a write");

   a_colour_port_stable: // R9
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_COLOUR_PORT)) |=> $stable(colour_port))
      else $error("colour port changed without a write");

   a_pkt_len_write: // R10
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_PKT_LEN)) |=> (udp_pkt_len == $past(wdata)))
      else $error("packet length write not taken");

   a_pkt_len_stable: // R10
   assert property (@(posedge clk) disable iff (!nrst)
      !(wr_strobe && hit(addr, CNC_OFF_PKT_LEN)) |=> $stable(udp_pkt_len))
      else $error("packet length changed without a write");

   a_stream_commit: // R5
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_STREAM_HIGH)) |=> (stream_dest_addr[31:16] == $past(wdata)))
      else $error("stream high write did not update destination");

   a_stream_low_held: // R4
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_STREAM_LOW)) |=> $stable(stream_dest_addr))
      else $error("stream low write changed active destination");

   a_colour_low_held: // R11
   assert property (@(posedge clk) disable iff (!nrst)
      (wr_strobe && hit(addr, CNC_OFF_COLOUR_LOW)) |=> $stable(colour_dest_addr))
      else $error("colour low write changed active destination");

   a_adv_readback: // R1
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_strobe && hit(addr, CNC_OFF_ADV_CTRL)) |=> (rdata[CNC_BIT_HDR] == $past(hdr_combine_en)
         && rdata[CNC_BIT_PATH_CORR] == $past(path_corr_en) && rdata[CNC_BIT_VERNIER] == $past(vernier_en)))
      else $error("control word readback disagrees with enables");

   a_unmapped_read_zero:
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_strobe && !mapped(addr)) |=> (rdata == CNC_RDATA_ZERO))
      else $error("unmapped read returned data");
endmodule : cnc_net_adv_config_regs

// file: cnc_net_adv_config_regs_tb.sv
`timescale 1ns/100ps
module cnc_net_adv_config_regs_tb;
   import cnc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic [15:0] rdata;
   logic [15:0] link_rate_mbps = CNC_RST_LINK_RATE;
   logic hdr_combine_en, path_corr_en, vernier_en;
   logic [15:0] ctrl_tcp_port, stream_port, colour_port, udp_pkt_len;
   logic [31:0] stream_dest_addr, colour_dest_addr;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [15:0] rd_val;

   cnc_net_adv_config_regs dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rdata(rdata), .link_rate_mbps(link_rate_mbps), .hdr_combine_en(hdr_combine_en),
      .path_corr_en(path_corr_en), .vernier_en(vernier_en), .ctrl_tcp_port(ctrl_tcp_port),
      .stream_dest_addr(stream_dest_addr), .stream_port(stream_port), .colour_dest_addr(colour_dest_addr),
      .colour_port(colour_port), .udp_pkt_len(udp_pkt_len));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic tally_and_finish;
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Ceiling well above the fewer than a hundred cycles the scenarios need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches = mismatches + 1;
         $display("Error at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   // Returns one step after the sampling edge, so outputs have settled
   task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      wr_strobe <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_strobe <= 1'b0;
      #1;
   endtask : bus_wr

   task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      rd_strobe <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd

   // Two writes with no idle cycle between them
   task automatic bus_wr_pair(input logic [15:0] a0, input logic [15:0] d0, input logic [15:0] a1,
                              input logic [15:0] d1);
      @(posedge clk);
      wr_strobe <= 1'b1;
      addr <= a0;
      wdata <= d0;
      @(posedge clk);
      addr <= a1;
      wdata <= d1;
      @(posedge clk);
      wr_strobe <= 1'b0;
      #1;
   endtask : bus_wr_pair

   task automatic test_reset_values;
      logic [15:0] offs [10];
      logic [15:0] vals [10];
      offs = '{CNC_OFF_ADV_CTRL, CNC_OFF_TCP_PORT, CNC_OFF_STREAM_LOW, CNC_OFF_STREAM_HIGH, CNC_OFF_STREAM_PORT,
         CNC_OFF_COLOUR_LOW, CNC_OFF_COLOUR_HIGH, CNC_OFF_COLOUR_PORT, CNC_OFF_PKT_LEN, CNC_OFF_LINK_RATE};
      vals = '{16'h0000, 16'h2711, 16'h0001, 16'hE000, 16'h2712, 16'h0001, 16'hE000, 16'h2716, 16'h0578, 16'h03E8};
      cmp({29'h0, hdr_combine_en, path_corr_en, vernier_en}, 32'h0, "enables");
      cmp(ctrl_tcp_port, 32'h2711, "tcp port");
      cmp(stream_port, 32'h2712, "stream port");
      cmp(colour_port, 32'h2716, "colour port");
      cmp(udp_pkt_len, 32'h0578, "pkt len");
      cmp(stream_dest_addr, 32'hE000_0001, "stream dest");
      cmp(colour_dest_addr, 32'hE000_0001, "colour dest");
      cmp(rdata, 32'h0, "idle rdata");
      for (int i = 0; i < 10; i++) begin
         bus_rd(offs[i], rd_val);
         cmp(rd_val, vals[i], "reset read");
      end
   endtask : test_reset_values

   task automatic test_adv_ctrl;
      bus_wr(CNC_OFF_ADV_CTRL, 16'hFF89);
      cmp({29'h0, hdr_combine_en, path_corr_en, vernier_en}, 32'h7, "all enables");
      bus_wr(CNC_OFF_ADV_CTRL, 16'h0008);
      cmp({29'h0, hdr_combine_en, path_corr_en, vernier_en}, 32'h2, "path only");
      bus_wr(CNC_OFF_ADV_CTRL, 16'h0080);
      cmp({29'h0, hdr_combine_en, path_corr_en, vernier_en}, 32'h1, "vernier only");
      bus_wr(CNC_OFF_ADV_CTRL, 16'h0001);
      cmp({29'h0, hdr_combine_en, path_corr_en, vernier_en}, 32'h4, "hdr only");
      bus_wr(CNC_OFF_ADV_CTRL, 16'hFF76);
      cmp({29'h0, hdr_combine_en, path_corr_en, vernier_en}, 32'h0, "other bits");
      bus_rd(CNC_OFF_ADV_CTRL, rd_val);
      cmp(rd_val, 32'hFF76, "adv readback");
   endtask : test_adv_ctrl

   task automatic test_depth_commit;
      bus_wr(CNC_OFF_STREAM_LOW, 16'hA5C3);
      cmp(stream_dest_addr, 32'hE000_0001, "low held");
      bus_wr(CNC_OFF_STREAM_HIGH, 16'hC0A8);
      cmp(stream_dest_addr, 32'hC0A8_A5C3, "depth commit");
      bus_wr(CNC_OFF_STREAM_HIGH, 16'h0A00);
      cmp(stream_dest_addr, 32'h0A00_A5C3, "high only");
      cmp(colour_dest_addr, 32'hE000_0001, "colour untouched");
      bus_wr_pair(CNC_OFF_STREAM_LOW, 16'h0102, CNC_OFF_STREAM_HIGH, 16'h0A0B);
      cmp(stream_dest_addr, 32'h0A0B_0102, "back to back commit");
   endtask : test_depth_commit

   task automatic test_colour_commit;
      bus_wr(CNC_OFF_COLOUR_LOW, 16'h1234);
      cmp(colour_dest_addr, 32'hE000_0001, "colour low held");
      bus_rd(CNC_OFF_COLOUR_LOW, rd_val);
      cmp(rd_val, 32'h1234, "pending low read");
      cmp(colour_dest_addr, 32'hE000_0001, "still held");
      bus_wr(CNC_OFF_COLOUR_HIGH, 16'h5678);
      cmp(colour_dest_addr, 32'h5678_1234, "colour commit");
      cmp(stream_dest_addr, 32'h0A0B_0102, "depth untouched");
   endtask : test_colour_commit

   task automatic test_ports_and_ro;
      bus_wr(CNC_OFF_TCP_PORT, 16'hFFFF);
      cmp(ctrl_tcp_port, 32'hFFFF, "tcp port");
      bus_wr(CNC_OFF_STREAM_PORT, 16'h1F90);
      cmp(stream_port, 32'h1F90, "stream port");
      bus_wr(CNC_OFF_COLOUR_PORT, 16'h0000);
      cmp(colour_port, 32'h0, "colour port");
      bus_wr(CNC_OFF_PKT_LEN, 16'h05DC);
      cmp(udp_pkt_len, 32'h05DC, "pkt len");
      bus_rd(CNC_OFF_PKT_LEN, rd_val);
      cmp(rd_val, 32'h05DC, "pkt len read");
      @(posedge clk);
      link_rate_mbps <= 16'h2710;
      bus_wr(CNC_OFF_LINK_RATE, 16'h0064);
      bus_rd(CNC_OFF_LINK_RATE, rd_val);
      cmp(rd_val, 32'h2710, "link rate");
      bus_wr(16'h0300, 16'hBEEF);
      bus_rd(16'h0300, rd_val);
      cmp(rd_val, 32'h0, "unmapped read");
      cmp(ctrl_tcp_port, 32'hFFFF, "unmapped write");
   endtask : test_ports_and_ro

   task automatic test_mid_reset;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1;
      cmp(ctrl_tcp_port, 32'h2711, "tcp port after reset");
      cmp(stream_port, 32'h2712, "stream port after reset");
      cmp(colour_port, 32'h2716, "colour port after reset");
      cmp(udp_pkt_len, 32'h0578, "pkt len after reset");
      cmp(stream_dest_addr, 32'hE000_0001, "stream dest after reset");
      cmp(colour_dest_addr, 32'hE000_0001, "colour dest after reset");
      bus_rd(CNC_OFF_COLOUR_LOW, rd_val);
      cmp(rd_val, 32'h0001, "colour low after reset");
   endtask : test_mid_reset

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      #1;
      test_reset_values();
      test_adv_ctrl();
      test_depth_commit();
      test_colour_commit();
      test_ports_and_ro();
      test_mid_reset();
      tally_and_finish();
   end
endmodule : cnc_net_adv_config_regs_tb
